// >>> inc/sdcd_map.svh
// Constant map for the command and power-state decoder
`ifndef SDCD_MAP_SVH
`define SDCD_MAP_SVH
`define SDCD_BANK_W          3
`define SDCD_ROW_W           14
`define SDCD_LANES           2
`define SDCD_LANE_W          8
`define SDCD_NUM_BANKS       8
`define SDCD_BL8_BEATS       4'h8
`define SDCD_BC4_BEATS       4'h4
`define SDCD_BL_FIXED8       2'h0
`define SDCD_BL_OTF          2'h1
`define SDCD_BL_FIXED4       2'h2
`define SDCD_PRE_CYCLES      8'h05
`define SDCD_REF_CYCLES      8'h40
`define SDCD_ZQ_CYCLES       8'h40
`define SDCD_MRD_CYCLES      8'h04
`define SDCD_XS_CYCLES       8'h08
`define SDCD_XP_CYCLES       8'h03
`define SDCD_MR0_RESET       14'h0000
`endif

// >>> inc/sdcd_pkg.sv
// Types shared by the command and power-state decoder
package sdcd_pkg;
	typedef enum logic [3:0] {
		CMD_DESELECT, CMD_NO_OPERATION, CMD_MODE_LOAD, CMD_REFRESH,
		CMD_SELF_REFRESH_ENTRY, CMD_ACTIVATE, CMD_PRECHARGE, CMD_PRECHARGE_ALL,
		CMD_READ, CMD_WRITE, CMD_CALIBRATE, CMD_POWER_DOWN_ENTRY,
		CMD_POWER_EXIT, CMD_ILLEGAL
	} sdcd_cmd_t;
	typedef enum logic [3:0] {
		ST_IDLE, ST_BANK_ACTIVE, ST_READING, ST_WRITING, ST_PRECHARGING,
		ST_REFRESHING, ST_PRECHARGE_PD, ST_ACTIVE_PD, ST_SELF_REFRESH
	} sdcd_state_t;
endpackage : sdcd_pkg

// >>> verilog/sdcd_cmd_decode.sv
// Combinational command decoder from strobe and enable levels
`timescale 1ns/1ps
`default_nettype none
module sdcd_cmd_decode
	import sdcd_pkg::*;
(
	// Sampled strobes
	input  wire logic          enablePrev,
	input  wire logic          enableNow,
	input  wire logic          chipSelectN,
	input  wire logic          rowStrobeN,
	input  wire logic          colStrobeN,
	input  wire logic          writeStrobeN,
	input  wire logic          addrAllBanks,
	// Decoded command
	output sdcd_pkg::sdcd_cmd_t cmd
);
	// Chip select high makes every other strobe except the enable levels a don't care
	always_comb begin
		cmd = CMD_ILLEGAL;
		if (chipSelectN) begin
			if (enablePrev == enableNow)
				cmd = CMD_DESELECT;
			else if (enablePrev)
				cmd = CMD_POWER_DOWN_ENTRY;
			else
				cmd = CMD_POWER_EXIT;
		end else if (enablePrev && enableNow) begin
			case ({rowStrobeN, colStrobeN, writeStrobeN})
				3'h0: cmd = CMD_MODE_LOAD;
				3'h1: cmd = CMD_REFRESH;
				3'h2: cmd = addrAllBanks ? CMD_PRECHARGE_ALL : CMD_PRECHARGE;
				3'h3: cmd = CMD_ACTIVATE;
				3'h4: cmd = CMD_WRITE;
				3'h5: cmd = CMD_READ;
				3'h6: cmd = CMD_CALIBRATE;
				3'h7: cmd = CMD_NO_OPERATION;
				default: cmd = CMD_ILLEGAL;
			endcase
		end else if (enablePrev) begin
			if ({rowStrobeN, colStrobeN, writeStrobeN} == 3'h1)
				cmd = CMD_SELF_REFRESH_ENTRY;
			else if ({rowStrobeN, colStrobeN, writeStrobeN} == 3'h7)
				cmd = CMD_POWER_DOWN_ENTRY;
		end else if (!enableNow) begin
			cmd = CMD_DESELECT;
		end else if ({rowStrobeN, colStrobeN, writeStrobeN} == 3'h7) begin
			cmd = CMD_POWER_EXIT;
		end
	end
endmodule : sdcd_cmd_decode
`default_nettype wire

// >>> verilog/sdcd_decoder.sv
// Command decoder and power-state tracker for a low-voltage DRAM device
`timescale 1ns/1ps
`default_nettype none
`include "sdcd_map.svh"
module sdcd_decoder
	import sdcd_pkg::*;
#(
	parameter int BANK_W = `SDCD_BANK_W,
	parameter int ROW_W  = `SDCD_ROW_W,
	parameter int LANES  = `SDCD_LANES,
	parameter int LANE_W = `SDCD_LANE_W
) (
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    nrst,
	// Command pins
	input  wire logic                    clockEnable,
	input  wire logic                    chipSelectN,
	input  wire logic                    rowStrobeN,
	input  wire logic                    colStrobeN,
	input  wire logic                    writeStrobeN,
	input  wire logic [BANK_W-1:0]       bankSelect,
	input  wire logic [ROW_W-1:0]        address,
	input  wire logic                    termination_control,
	// Write data path
	input  wire logic [LANES*LANE_W-1:0] writeData,
	input  wire logic [LANES-1:0]        data_mask,
	// Status
	output logic [3:0]                   currentCmd,
	output logic [3:0]                   powerState,
	output logic [(1<<BANK_W)-1:0]       bankOpen,
	output logic [BANK_W-1:0]            targetBank,
	output logic                         modeLoadStrobe,
	output logic [ROW_W-1:0]             modeLoadValue,
	output logic                         refreshStrobe,
	output logic                         terminationActive,
	output logic                         idleReady,
	output logic                         illegalCmd,
	output logic                         storeValid,
	output logic [LANES*LANE_W-1:0]      storeData,
	output logic [LANES-1:0]             storeLaneEnable
);
	localparam int NB = 1 << BANK_W;

	sdcd_cmd_t   cmd;
	logic        enablePrev_q, enablePrev_d;
	sdcd_state_t state_q, state_d;
	logic [NB-1:0] open_q, open_d;
	logic [3:0]  beats_q, beats_d;
	logic        burstWrite_q, burstWrite_d;
	logic [7:0]  wait_q, wait_d;
	logic [1:0]  blMode_q, blMode_d;
	logic [BANK_W-1:0] bank_q, bank_d;
	logic        mrs_q, mrs_d, ref_q, ref_d, ill_q, ill_d;
	logic [ROW_W-1:0] mrv_q, mrv_d;
	logic        stV_q, stV_d;
	logic [LANES*LANE_W-1:0] stD_q, stD_d;
	logic [LANES-1:0] stE_q, stE_d;
	logic        srSeen_q, srSeen_d, srWake_q;

	// Pure strobe decode; termination input is not an input here
	sdcd_cmd_decode u_dec (
		.enablePrev  (enablePrev_q),
		.enableNow   (clockEnable),
		.chipSelectN (chipSelectN),
		.rowStrobeN  (rowStrobeN),
		.colStrobeN  (colStrobeN),
		.writeStrobeN(writeStrobeN),
		.addrAllBanks(address[10]),
		.cmd         (cmd)
	);

	// Asynchronous wake from self refresh: enable rising needs no clock
	always_ff @(posedge clockEnable or negedge nrst) begin
		if (!nrst)
			srWake_q <= 1'b0;
		else
			srWake_q <= ~srWake_q;
	end

	// Next state, judged from the state before this edge
	always_comb begin
		logic burstBusy;
		logic sdcClosed;
		burstBusy   = 1'b0;
		sdcClosed   = 1'b0;
		state_d      = state_q;
		open_d       = open_q;
		beats_d      = beats_q;
		burstWrite_d = burstWrite_q;
		wait_d       = (wait_q != 8'h00) ? wait_q - 8'h01 : 8'h00;
		blMode_d     = blMode_q;
		bank_d       = bank_q;
		enablePrev_d = clockEnable;
		srSeen_d     = srWake_q;
		mrs_d = 1'b0;
		ref_d = 1'b0;
		ill_d = 1'b0;
		mrv_d = mrv_q;
		stV_d = 1'b0;
		stD_d = stD_q;
		stE_d = '0;
		burstBusy = (beats_q != 4'h0);
		// A running burst counts down whatever arrives next
		if (burstBusy) begin
			beats_d = beats_q - 4'h1;
			if (burstWrite_q) begin
				stV_d = 1'b1;
				stD_d = writeData;
				stE_d = ~data_mask;
			end
		end
		sdcClosed = (open_d == '0);
		case (state_q)
			ST_SELF_REFRESH: begin
				if (srSeen_q != srWake_q || clockEnable) begin
					state_d = ST_IDLE;
					wait_d  = `SDCD_XS_CYCLES;
				end
			end
			ST_PRECHARGE_PD, ST_ACTIVE_PD: begin
				// No refresh is ever scheduled from here
				if (cmd == CMD_POWER_EXIT) begin
					state_d = (state_q == ST_ACTIVE_PD) ? ST_BANK_ACTIVE : ST_IDLE;
					wait_d  = `SDCD_XP_CYCLES;
				end
			end
			default: begin
				case (cmd)
					// Enable's first rise after reset decodes as an exit; treat as no-op
					CMD_DESELECT, CMD_NO_OPERATION, CMD_POWER_EXIT: ;
					CMD_POWER_DOWN_ENTRY: begin
						if (state_q == ST_REFRESHING || sdcClosed)
							state_d = ST_PRECHARGE_PD;
						else
							state_d = ST_ACTIVE_PD;
						// A running burst keeps counting through power-down
					end
					CMD_SELF_REFRESH_ENTRY: begin
						if (idleReady)
							state_d = ST_SELF_REFRESH;
						else
							ill_d = 1'b1;
					end
					CMD_MODE_LOAD: begin
						mrs_d = 1'b1;
						mrv_d = address;
						bank_d = bankSelect;
						if (bankSelect == '0)
							blMode_d = address[1:0];
						wait_d = `SDCD_MRD_CYCLES;
					end
					CMD_REFRESH: begin
						ref_d   = 1'b1;
						state_d = ST_REFRESHING;
						wait_d  = `SDCD_REF_CYCLES;
					end
					CMD_ACTIVATE: begin
						bank_d = bankSelect;
						open_d[bankSelect] = 1'b1;
						state_d = ST_BANK_ACTIVE;
					end
					CMD_PRECHARGE, CMD_PRECHARGE_ALL: begin
						if (cmd == CMD_PRECHARGE_ALL)
							open_d = '0;
						else
							open_d[bankSelect] = 1'b0;
						bank_d  = bankSelect;
						state_d = ST_PRECHARGING;
						wait_d  = `SDCD_PRE_CYCLES;
					end
					CMD_READ, CMD_WRITE: begin
						if (burstBusy) begin
							ill_d = 1'b1;
						end else begin
							bank_d = bankSelect;
							burstWrite_d = (cmd == CMD_WRITE);
							state_d = (cmd == CMD_WRITE) ? ST_WRITING : ST_READING;
							if (blMode_q == `SDCD_BL_FIXED4 ||
									(blMode_q == `SDCD_BL_OTF && !address[12]))
								beats_d = `SDCD_BC4_BEATS;
							else
								beats_d = `SDCD_BL8_BEATS;
							if (address[10])
								open_d[bankSelect] = 1'b0;
						end
					end
					CMD_CALIBRATE: wait_d = `SDCD_ZQ_CYCLES;
					default: ill_d = 1'b1;
				endcase
				// Settle back once bursts and timers are done
				if (state_d == state_q && beats_d == 4'h0 && wait_d == 8'h00 &&
						state_q != ST_IDLE)
					state_d = (open_d == '0) ? ST_IDLE : ST_BANK_ACTIVE;
			end
		endcase
	end

	// Register all decoder state except srWake_q, which toggles on the enable edge
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_q      <= ST_IDLE;
			open_q       <= '0;
			beats_q      <= 4'h0;
			burstWrite_q <= 1'b0;
			wait_q       <= 8'h00;
			blMode_q     <= `SDCD_BL_FIXED8;
			bank_q       <= '0;
			enablePrev_q <= 1'b0;
			srSeen_q     <= 1'b0;
			mrs_q <= 1'b0;
			ref_q <= 1'b0;
			ill_q <= 1'b0;
			mrv_q <= `SDCD_MR0_RESET;
			stV_q <= 1'b0;
			stD_q <= '0;
			stE_q <= '0;
		end else begin
			state_q      <= state_d;
			open_q       <= open_d;
			beats_q      <= beats_d;
			burstWrite_q <= burstWrite_d;
			wait_q       <= wait_d;
			blMode_q     <= blMode_d;
			bank_q       <= bank_d;
			enablePrev_q <= enablePrev_d;
			srSeen_q     <= srSeen_d;
			mrs_q <= mrs_d;
			ref_q <= ref_d;
			ill_q <= ill_d;
			mrv_q <= mrv_d;
			stV_q <= stV_d;
			stD_q <= stD_d;
			stE_q <= stE_d;
		end
	end

	// Idle qualification from live state
	assign idleReady = (open_q == '0) && (beats_q == 4'h0) && enablePrev_q &&
		(wait_q == 8'h00);
	// Termination gated off in self refresh only
	assign terminationActive = termination_control && (state_q != ST_SELF_REFRESH);
	assign currentCmd      = cmd;
	assign powerState      = state_q;
	assign bankOpen        = open_q;
	assign targetBank      = bank_q;
	assign modeLoadStrobe  = mrs_q;
	assign modeLoadValue   = mrv_q;
	assign refreshStrobe   = ref_q;
	assign illegalCmd      = ill_q;
	assign storeValid      = stV_q;
	assign storeData       = stD_q;
	assign storeLaneEnable = stE_q;
endmodule : sdcd_decoder
`default_nettype wire

// >>> test/sdcd_chk.sv
// Port-level assertions for the command and power-state decoder
`timescale 1ns/1ps
`default_nettype none
module sdcd_chk
	import sdcd_pkg::*;
#(
	parameter int BANK_W = 3,
	parameter int ROW_W  = 14,
	parameter int LANES  = 2,
	parameter int LANE_W = 8
) (
	// Clock and reset
	input wire logic                    clk_sys,
	input wire logic                    nrst,
	// Inputs watched
	input wire logic                    clockEnable,
	input wire logic                    chipSelectN,
	input wire logic [ROW_W-1:0]        address,
	input wire logic                    termination_control,
	input wire logic [LANES*LANE_W-1:0] writeData,
	input wire logic [LANES-1:0]        data_mask,
	// Outputs watched
	input wire logic [3:0]              currentCmd,
	input wire logic [3:0]              powerState,
	input wire logic [(1<<BANK_W)-1:0]  bankOpen,
	input wire logic                    modeLoadStrobe,
	input wire logic [ROW_W-1:0]        modeLoadValue,
	input wire logic                    refreshStrobe,
	input wire logic                    terminationActive,
	input wire logic                    idleReady,
	input wire logic                    storeValid,
	input wire logic [LANES*LANE_W-1:0] storeData,
	input wire logic [LANES-1:0]        storeLaneEnable
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic enPrev_q;
	// Enable at the previous edge; cleared in reset so a_desel_cmd never checks the first edge after reset
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			enPrev_q <= 1'h0;
		end else begin
			enPrev_q <= clockEnable;
		end
	end
	a_desel_cmd: assert property (enPrev_q && clockEnable && chipSelectN
		|-> currentCmd == CMD_DESELECT) else $error("deselect decoded wrongly");
	a_mode_value: assert property (modeLoadStrobe
		|-> modeLoadValue == $past(address)) else $error("mode value not taken");
	a_pd_idle: assert property (enPrev_q && !clockEnable && chipSelectN && idleReady
		|=> powerState == ST_PRECHARGE_PD) else $error("no precharge power-down");
	a_pd_active: assert property (enPrev_q && !clockEnable && chipSelectN
		&& powerState == ST_BANK_ACTIVE |=> powerState == ST_ACTIVE_PD)
		else $error("no active power-down");
	a_pd_norefresh: assert property (powerState inside {ST_PRECHARGE_PD, ST_ACTIVE_PD}
		|-> !refreshStrobe) else $error("refresh in power-down");
	a_sr_from_idle: assert property ($rose(powerState == ST_SELF_REFRESH)
		|-> $past(idleReady)) else $error("self refresh not from idle");
	a_odt_off_sr: assert property (terminationActive ==
		(termination_control && powerState != ST_SELF_REFRESH)) else $error("termination wrong");
	a_burst_whole: assert property ($rose(storeValid) |-> storeValid[*4])
		else $error("burst cut short");
	a_mask_lanes: assert property (storeValid |-> storeLaneEnable == ~$past(data_mask)
		&& storeData == $past(writeData)) else $error("lane store wrong");
	a_idle_closed: assert property (idleReady |-> bankOpen == '0
		&& powerState == ST_IDLE) else $error("idle with bank open");
	// Main scenarios reached
	c_store: cover property (storeValid);
	c_selfref: cover property (powerState == ST_SELF_REFRESH);
	c_actpd: cover property (powerState == ST_ACTIVE_PD);
endmodule : sdcd_chk
`default_nettype wire

// >>> test/sdcd_ctrl_model.sv
// Memory controller model driving command pins at the falling edge
`timescale 1ns/1ps
`default_nettype none
module sdcd_ctrl_model (
	// Clock
	input  wire logic        clk_sys,
	// Command pins
	output var logic        clockEnable,
	output var logic        chipSelectN,
	output var logic        rowStrobeN,
	output var logic        colStrobeN,
	output var logic        writeStrobeN,
	output var logic [2:0]  bankSelect,
	output var logic [13:0] address,
	// Write data
	output var logic [15:0] writeData,
	output var logic [1:0]  data_mask
);
	// Enable low and a no-operation until the first command
	initial begin
		{clockEnable, bankSelect, address, writeData, data_mask} = '0;
		{chipSelectN, rowStrobeN, colStrobeN, writeStrobeN} = 4'h7;
	end
	// One command per cycle; a deselect flips the ignored strobes so they never matter
	task automatic issue(input logic cke, input logic [3:0] c,
		input logic [16:0] a, input logic [17:0] d);
		@(negedge clk_sys);
		clockEnable = cke;
		chipSelectN = c[3];
		if (c[3]) begin
			{rowStrobeN, colStrobeN, writeStrobeN} = ~{rowStrobeN, colStrobeN, writeStrobeN};
		end else begin
			{rowStrobeN, colStrobeN, writeStrobeN} = c[2:0];
		end
		{bankSelect, address} = a;
		{data_mask, writeData} = d;
	endtask : issue
endmodule : sdcd_ctrl_model
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the command and power-state decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sdcd_pkg::*;
	localparam logic [3:0] K_NOOP = 4'h7, K_DES = 4'hF, K_MODE = 4'h0, K_REF = 4'h1;
	localparam logic [3:0] K_ACT = 4'h3, K_PRE = 4'h2, K_RD = 4'h5, K_WR = 4'h4, K_CAL = 4'h6;
	logic clk_sys, nrst, termination_control;
	wire logic clockEnable, chipSelectN, rowStrobeN, colStrobeN, writeStrobeN;
	wire logic [2:0] bankSelect, targetBank;
	wire logic [13:0] address, modeLoadValue;
	wire logic [15:0] writeData, storeData;
	wire logic [1:0] data_mask, storeLaneEnable;
	wire logic [3:0] currentCmd, powerState;
	wire logic [7:0] bankOpen;
	wire logic modeLoadStrobe, refreshStrobe, terminationActive, idleReady;
	wire logic illegalCmd, storeValid;
	logic [31:0] seed = 32'hA5521803;
	logic [31:0] r;
	logic [2:0] b;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;
	int n;
	sdcd_decoder uut (.*);
	sdcd_ctrl_model m (.*);
	initial begin
		clk_sys = 1'h0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report
	// Random write data and mask ride along with every command
	task automatic op(input logic cke, input logic [3:0] c, input logic [16:0] a);
		logic [31:0] d;
		d = rnd();
		m.issue(cke, c, a, d[17:0]);
	endtask : op
	// Bounded wait for the idle qualification
	task automatic wait_idle();
		for (int i = 0; i < 100 && idleReady !== 1'h1; i++) begin
			op(1'h1, K_NOOP, '0);
		end
		check(idleReady, 1'h1);
	endtask : wait_idle
	// Cut a hang short
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			final_report();
		end
	end
	initial begin
		termination_control = 1'h0;
		nrst = 1'h0;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		nrst = 1'h1;
		op(1'h1, K_NOOP, '0);
		check(powerState, ST_IDLE);
		wait_idle();
		for (int i = 0; i < 4; i++) begin
			op(1'h1, K_DES, 17'(rnd()));
			#1 check(currentCmd, CMD_DESELECT);
		end
		r = rnd();
		op(1'h1, K_MODE, {3'h0, r[13:2], 2'h0});
		op(1'h1, K_NOOP, '0);
		check(modeLoadStrobe, 1'h1);
		check(modeLoadValue, {r[13:2], 2'h0});
		wait_idle();
		op(1'h1, K_REF, '0);
		op(1'h1, K_NOOP, '0);
		check(refreshStrobe, 1'h1);
		wait_idle();
		// Calibration holds idle off in the cycle after it is issued
		op(1'h1, K_CAL, 17'h00400);
		op(1'h1, K_NOOP, '0);
		check(idleReady, 1'h0);
		wait_idle();
		$display("decode tests done");
		r = rnd();
		b = r[16:14];
		op(1'h1, K_ACT, {b, r[13:0]});
		op(1'h1, K_NOOP, '0);
		check(bankOpen, 8'h01 << b);
		check(targetBank, b);
		check(powerState, ST_BANK_ACTIVE);
		op(1'h1, K_WR, {b, 14'h0000});
		n = 0;
		// A read mid-burst is refused and the burst runs on
		for (int i = 0; i < 12; i++) begin
			op(1'h1, (i == 2) ? K_RD : K_NOOP, {b, 14'h0000});
			if (i == 3) check(illegalCmd, 1'h1);
			if (storeValid === 1'h1) n++;
		end
		check(n, 8);
		check(powerState, ST_BANK_ACTIVE);
		$display("burst tests done");
		repeat (4) op(1'h0, K_NOOP, '0);
		check(powerState, ST_ACTIVE_PD);
		repeat (6) op(1'h1, K_DES, 17'(rnd()));
		check(powerState, ST_BANK_ACTIVE);
		op(1'h1, K_PRE, 17'h00400);
		wait_idle();
		check(bankOpen, 8'h00);
		// Refresh patterns while held down must not start a refresh
		for (int i = 0; i < 6; i++) begin
			op(1'h0, (i == 0) ? K_DES : K_REF, 17'(rnd()));
			check(refreshStrobe, 1'h0);
		end
		check(powerState, ST_PRECHARGE_PD);
		repeat (6) op(1'h1, K_NOOP, '0);
		wait_idle();
		$display("power-down tests done");
		termination_control = 1'h1;
		op(1'h0, K_REF, '0);
		repeat (4) op(1'h0, K_DES, 17'(rnd()));
		check(powerState, ST_SELF_REFRESH);
		check(terminationActive, 1'h0);
		repeat (12) op(1'h1, K_DES, 17'(rnd()));
		wait_idle();
		check(terminationActive, 1'h1);
		$display("self refresh tests done");
		// On-the-fly burst mode, then a chopped read that closes its own bank
		op(1'h1, K_MODE, 17'h00001);
		wait_idle();
		op(1'h1, K_ACT, {b, 14'h0000});
		// Only a read follows the activate, so no store is expected
		op(1'h1, K_RD, {b, 14'h0400});
		n = 0;
		for (int i = 0; i < 6; i++) begin
			op(1'h1, K_NOOP, '0);
			if (powerState === ST_READING) n++;
			check(storeValid, 1'h0);
		end
		check(n, 4);
		check(bankOpen, 8'h00);
		check(powerState, ST_IDLE);
		$display("read tests done");
		final_report();
	end
endmodule : testbench
bind sdcd_decoder sdcd_chk #(.BANK_W(BANK_W), .ROW_W(ROW_W), .LANES(LANES), .LANE_W(LANE_W)) chk (.*);
`default_nettype wire
